// ---- core/aof_formatter.sv ----
// Purpose: output formatting and forwarding of converter samples
// Assumes: encode clock arrives as a pin sampled by SYS_CLK
// Notes: one sample per encode period, output clock built from edges
//
// Function
// - stabilizer gives 50% duty from 30-70% input
// - stabilizer relocks after one hundred cycles
// - stabilizer enable from register or select pin
// - three output modes, pin excludes DDR CMOS
// - pin low CMOS, high LVDS 3.5mA
// - full rate drives all 14 bits
// - DDR CMOS muxes two bits on seven lanes
// - even bit clock low, odd bit high
// - complement clock is inverse of true
// - DDR LVDS seven pairs plus flag, clock
// - LVDS drive default 3.5mA, seven levels
// - internal termination scales drive by 1.6x
// - range flag follows sample pipeline
// - full rate data changes on clock fall
// - DDR data changes on both clock edges
// - clock delay 0, 45, 90, 135 degrees
// - clock invert adds 180 degrees
// - offset binary default, twos complement selectable
// - twos complement inverts top bit, saturates
// - randomizer xors LSB into other bits
// - alternate polarity inverts odd bits
// - alternate polarity forces offset binary
`timescale 1ns/1ps
module aof_formatter
	import aof_pkg::*;
#(
	parameter int WIDTH = 14,
	parameter int PHASE_STEPS = 8
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic ENC_CLK,
	input wire logic [WIDTH-1:0] SAMPLE_IN,
	input wire logic OVER_RANGE,
	input wire logic UNDER_RANGE,
	input wire logic PROGRAM_MODE_PIN,
	input wire logic CS_PIN,
	input wire logic SCK_PIN,
	input wire logic [6:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic [WIDTH-1:0] SAMPLE_BITS,
	output logic [WIDTH/2-1:0] DDR_PAIR_LANE_P,
	output logic [WIDTH/2-1:0] DDR_PAIR_LANE_N,
	output logic RANGE_FLAG_P,
	output logic RANGE_FLAG_N,
	output logic FWD_CLK_P,
	output logic FWD_CLK_N,
	output logic [1:0] MODE_OUT,
	output logic [6:0] LVDS_DRIVE_LEVEL,
	output logic INTERNAL_TERM_ENABLE,
	output logic DUTY_STABILIZER,
	output logic DCS_LOCKED
);
	// ****************************************************
	// registers
	// ****************************************************
	logic [7:0] timing_reg_ff;
	logic [7:0] output_mode_reg_ff;
	logic [7:0] data_format_reg_ff;
	logic [7:0] rdata_ff;
	logic [2:0] enc_sync_ff;
	logic [2:0] pin_sync_ff;
	logic [2:0] cs_sync_ff;
	logic [2:0] sck_sync_ff;
	logic enc_lvl_ff;
	logic pmode_ff;
	logic cs_ff;
	logic sck_ff;
	logic [7:0] period_ff;
	logic [7:0] cnt_ff;
	logic [7:0] last_period_ff;
	logic [6:0] lock_cnt_ff;
	logic [WIDTH-1:0] word_ff;
	logic flag_ff;

	wire wr_timing = WR && (ADDR == AOF_TIMING_OFS);
	wire wr_mode = WR && (ADDR == AOF_OUTMODE_OFS);
	wire wr_format = WR && (ADDR == AOF_FORMAT_OFS);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			timing_reg_ff <= AOF_REG_RST;
			output_mode_reg_ff <= AOF_REG_RST;
			data_format_reg_ff <= AOF_REG_RST;
		end else begin
			if (wr_timing)
				timing_reg_ff <= WDATA;
			if (wr_mode)
				output_mode_reg_ff <= WDATA;
			if (wr_format)
				data_format_reg_ff <= WDATA;
		end
	end

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	// a level counts once the last two stages agree
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			enc_sync_ff <= 3'h0;
			pin_sync_ff <= 3'h0;
			cs_sync_ff <= 3'h0;
			sck_sync_ff <= 3'h0;
			enc_lvl_ff <= 1'b0;
			pmode_ff <= 1'b0;
			cs_ff <= 1'b0;
			sck_ff <= 1'b0;
		end else begin
			enc_sync_ff <= {enc_sync_ff[1:0], ENC_CLK};
			pin_sync_ff <= {pin_sync_ff[1:0], PROGRAM_MODE_PIN};
			cs_sync_ff <= {cs_sync_ff[1:0], CS_PIN};
			sck_sync_ff <= {sck_sync_ff[1:0], SCK_PIN};
			if (enc_sync_ff[2] == enc_sync_ff[1])
				enc_lvl_ff <= enc_sync_ff[2];
			if (pin_sync_ff[2] == pin_sync_ff[1])
				pmode_ff <= pin_sync_ff[2];
			if (cs_sync_ff[2] == cs_sync_ff[1])
				cs_ff <= cs_sync_ff[2];
			if (sck_sync_ff[2] == sck_sync_ff[1])
				sck_ff <= sck_sync_ff[2];
		end
	end

	// rise seen only while the filtered level is still low
	wire enc_rise = (enc_sync_ff[2] == enc_sync_ff[1]) &&
		enc_sync_ff[2] && !enc_lvl_ff;

	// ****************************************************
	// configuration selection
	// ****************************************************
	// parallel mode when program pin is high
	// parallel mode ignores shift, format and termination
	wire dcs_en = pmode_ff ? cs_ff : timing_reg_ff[AOF_DCS_BIT];
	wire [1:0] reg_mode = output_mode_reg_ff[AOF_MODE_LO +: 2];
	wire [1:0] pin_mode = sck_ff ? 2'(AOF_MODE_LVDS) :
		2'(AOF_MODE_CMOS);
	// reserved mode code falls back to full rate
	wire [1:0] mode_sel = pmode_ff ? pin_mode :
		((reg_mode == 2'(AOF_MODE_RSVD)) ? 2'(AOF_MODE_CMOS) :
		reg_mode);
	wire is_ddr = (mode_sel != 2'(AOF_MODE_CMOS));
	wire [2:0] reg_drive = output_mode_reg_ff[AOF_DRIVE_LO +: 3];
	wire drive_unused = (reg_drive == AOF_DRIVE_UNUSED);
	wire [2:0] drv_code = (pmode_ff || drive_unused) ?
		AOF_DRIVE_DEFAULT : reg_drive;
	wire term_en = !pmode_ff && output_mode_reg_ff[AOF_TERM_BIT];
	wire [1:0] phase_sel = pmode_ff ? 2'h0 :
		timing_reg_ff[AOF_PHASE_LO +: 2];
	wire clk_inv = !pmode_ff && timing_reg_ff[AOF_INV_BIT];
	wire twos = !pmode_ff && data_format_reg_ff[AOF_TWOS_BIT];
	wire lsb_xor_scramble_en = !pmode_ff && data_format_reg_ff[AOF_LSB_XOR_SCRAMBLE_BIT];
	wire abp_en = !pmode_ff && data_format_reg_ff[AOF_ABP_BIT];

	// drive current in twentieths of mA, so the lowest step stays exact
	logic [6:0] base_drive;
	always_comb begin
		case (drv_code)
		3'h0: base_drive = 7'h46;
		3'h1: base_drive = 7'h50;
		3'h2: base_drive = 7'h5a;
		3'h4: base_drive = 7'h3c;
		3'h5: base_drive = 7'h32;
		3'h6: base_drive = 7'h2a;
		default: base_drive = 7'h23;
		endcase
	end
	// reported in tenths of mA, rounded down
	wire [10:0] term_prod = 11'(base_drive) * 11'(AOF_TERM_NUM);
	wire [10:0] scaled = term_prod / 11'(2 * AOF_TERM_DEN);
	wire [6:0] base_tenths = base_drive >> 1;
	wire [6:0] drive_now = term_en ? scaled[6:0] : base_tenths;

	// ****************************************************
	// encode period and stabilizer lock
	// ****************************************************
	wire [7:0] cnt_inc = cnt_ff + 8'h01;
	wire period_same = (cnt_inc == last_period_ff);
	wire clk_stopped = (cnt_ff == 8'hff);
	wire lock_restart = !dcs_en || !period_same;
	wire lock_full = (lock_cnt_ff == 7'(AOF_LOCK_CYCLES));
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			cnt_ff <= 8'h00;
			period_ff <= 8'h08;
			last_period_ff <= 8'h00;
			lock_cnt_ff <= 7'h00;
		end else if (enc_rise) begin
			cnt_ff <= 8'h00;
			period_ff <= cnt_inc;
			last_period_ff <= cnt_inc;
			// relock after any frequency change
			if (lock_restart)
				lock_cnt_ff <= 7'h00;
			else if (!lock_full)
				lock_cnt_ff <= lock_cnt_ff + 7'h01;
		end else begin
			cnt_ff <= clk_stopped ? cnt_ff : cnt_inc;
			// stopped clock or stabilizer off: lose lock at once
			if (clk_stopped || !dcs_en)
				lock_cnt_ff <= 7'h00;
		end
	end

	// ****************************************************
	// sample formatting
	// ****************************************************
	// overrange wins when both flags are set
	wire sat_hi = OVER_RANGE;
	wire sat_lo = UNDER_RANGE && !OVER_RANGE;
	wire [WIDTH-1:0] ob_code = sat_hi ? {WIDTH{1'b1}} :
		(sat_lo ? {WIDTH{1'b0}} : SAMPLE_IN);
	wire [WIDTH-1:0] fmt_code = (twos && !abp_en) ?
		{~ob_code[WIDTH-1], ob_code[WIDTH-2:0]} : ob_code;
	logic [WIDTH-1:0] rnd_code;
	logic [WIDTH-1:0] out_code;
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			if (gi == 0) begin : g_lsb
				assign rnd_code[gi] = fmt_code[gi];
			end else begin : g_up
				assign rnd_code[gi] = fmt_code[gi] ^
					(lsb_xor_scramble_en & fmt_code[0]);
			end
			assign out_code[gi] = rnd_code[gi] ^
				(abp_en & (gi % 2 == 1));
		end
	endgenerate

	wire range_now = OVER_RANGE | UNDER_RANGE;
	// captured at each encode edge with its flag
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			word_ff <= '0;
			flag_ff <= 1'b0;
		end else if (enc_rise) begin
			word_ff <= out_code;
			flag_ff <= range_now;
		end
	end

	// ****************************************************
	// forwarded clock and lane driving
	// ****************************************************
	// phase within the period in eighths; 50% duty with or without the stabilizer
	wire [10:0] ph_num = 11'(cnt_ff) * 11'(PHASE_STEPS);
	wire [2:0] eighth = (period_ff == 8'h00) ? 3'h0 :
		3'(ph_num / 11'(period_ff));
	// each delay step holds the clock back one eighth of a period
	wire [2:0] delay_eighths = 3'(phase_sel);
	wire [2:0] shifted = eighth - delay_eighths;
	// clock low in the first half so data change on its fall
	wire clk_base = shifted[2] ^ 1'b0;
	wire clk_now = clk_base ^ clk_inv;
	wire ddr_hi = eighth[2];

	logic [WIDTH/2-1:0] lane_now;
	generate
		for (gi = 0; gi < WIDTH / 2; gi++) begin : g_lane
			// even bit in low half, odd bit in high half
			assign lane_now[gi] = ddr_hi ? word_ff[2*gi+1] :
				word_ff[2*gi];
		end
	endgenerate

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			SAMPLE_BITS <= '0;
			DDR_PAIR_LANE_P <= '0;
			DDR_PAIR_LANE_N <= '1;
			RANGE_FLAG_P <= 1'b0;
			RANGE_FLAG_N <= 1'b1;
			FWD_CLK_P <= 1'b0;
			FWD_CLK_N <= 1'b1;
		end else begin
			SAMPLE_BITS <= is_ddr ? '0 : word_ff;
			// lanes idle at P low, N high outside DDR modes
			DDR_PAIR_LANE_P <= is_ddr ? lane_now : '0;
			DDR_PAIR_LANE_N <= is_ddr ? ~lane_now : '1;
			RANGE_FLAG_P <= flag_ff;
			RANGE_FLAG_N <= ~flag_ff;
			FWD_CLK_P <= clk_now;
			FWD_CLK_N <= ~clk_now;
		end
	end

	// ****************************************************
	// status and read path
	// ****************************************************
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			MODE_OUT <= 2'h0;
			LVDS_DRIVE_LEVEL <= 7'h0;
			INTERNAL_TERM_ENABLE <= 1'b0;
			DUTY_STABILIZER <= 1'b0;
			DCS_LOCKED <= 1'b0;
		end else begin
			MODE_OUT <= mode_sel;
			LVDS_DRIVE_LEVEL <= drive_now;
			INTERNAL_TERM_ENABLE <= term_en;
			DUTY_STABILIZER <= dcs_en;
			DCS_LOCKED <= dcs_en &&
				lock_full;
		end
	end

	wire [7:0] status_word = {DCS_LOCKED, dcs_en, pmode_ff, 5'h00};
	logic [7:0] rd_mux;
	always_comb begin
		if (ADDR == AOF_TIMING_OFS)
			rd_mux = timing_reg_ff;
		else if (ADDR == AOF_OUTMODE_OFS)
			rd_mux = output_mode_reg_ff;
		else if (ADDR == AOF_FORMAT_OFS)
			rd_mux = data_format_reg_ff;
		else if (ADDR == AOF_STATUS_OFS)
			rd_mux = status_word;
		else
			rd_mux = 8'h00;
	end

	// read data stand one cycle, zero otherwise
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= RD ? rd_mux : 8'h00;
	end
	assign RDATA = rdata_ff;
endmodule : aof_formatter

// ---- core/aof_pkg.sv ----
// Purpose: constants for the converter output formatter
// Assumes: 25 MHz system clock, encode clock sampled as a pin
// Notes: register offsets follow the mode control map
package aof_pkg;
	// ****************************************************
	// register map
	// ****************************************************
	localparam logic [6:0] AOF_TIMING_OFS = 7'h02;
	localparam logic [6:0] AOF_OUTMODE_OFS = 7'h03;
	localparam logic [6:0] AOF_FORMAT_OFS = 7'h04;
	localparam logic [6:0] AOF_STATUS_OFS = 7'h05;
	localparam logic [7:0] AOF_REG_RST = 8'h00;
	// timing register fields
	localparam int AOF_DCS_BIT = 0;
	localparam int AOF_PHASE_LO = 1;
	localparam int AOF_INV_BIT = 3;
	// output mode register fields
	localparam int AOF_MODE_LO = 0;
	localparam int AOF_TERM_BIT = 3;
	localparam int AOF_DRIVE_LO = 4;
	// format register fields
	localparam int AOF_TWOS_BIT = 0;
	localparam int AOF_LSB_XOR_SCRAMBLE_BIT = 1;
	localparam int AOF_ABP_BIT = 2;
	// ****************************************************
	// counts and levels
	// ****************************************************
	localparam int AOF_LOCK_CYCLES = 100;
	localparam logic [2:0] AOF_DRIVE_DEFAULT = 3'h0;
	localparam logic [2:0] AOF_DRIVE_UNUSED = 3'h3;
	// drive current in twentieths of mA per code; termination scales 1.6x
	localparam int AOF_TERM_NUM = 16;
	localparam int AOF_TERM_DEN = 10;
	typedef enum logic [1:0] {
		AOF_MODE_CMOS,
		AOF_MODE_LVDS,
		AOF_MODE_DDRCMOS,
		AOF_MODE_RSVD
	} aof_mode_t;
endpackage : aof_pkg

// ---- bench/aof_checker.sv ----
// Purpose: port assertions of the output formatter
// Assumes: SYS_CLK domain only
// Notes: lock bound assumes an encode period of 8 cycles
`timescale 1ns/1ps
// ****************
// checker
// ****************
module aof_checker
	import aof_pkg::*;
#(
	parameter int WIDTH = 14
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic RD,
	input wire logic [6:0] ADDR,
	input wire logic [7:0] RDATA,
	input wire logic PROGRAM_MODE_PIN,
	input wire logic SCK_PIN,
	input wire logic [WIDTH/2-1:0] DDR_PAIR_LANE_P,
	input wire logic [WIDTH/2-1:0] DDR_PAIR_LANE_N,
	input wire logic RANGE_FLAG_P,
	input wire logic RANGE_FLAG_N,
	input wire logic FWD_CLK_P,
	input wire logic FWD_CLK_N,
	input wire logic [1:0] MODE_OUT,
	input wire logic DUTY_STABILIZER,
	input wire logic DCS_LOCKED
);
	localparam int LOCK_MIN = 780;
	logic [11:0] on_ff;
	wire [11:0] nxt_on = DUTY_STABILIZER ? on_ff + 12'(!(&on_ff)) : 12'h000;
	always_ff @(posedge SYS_CLK) begin
		on_ff <= RST_N ? nxt_on : 12'h000;
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	clk_pair_a: assert property (FWD_CLK_N == !FWD_CLK_P)
		else $error("clock pair not inverse");
	flag_pair_a: assert property (RANGE_FLAG_N == !RANGE_FLAG_P)
		else $error("flag pair not inverse");
	lane_pair_a: assert property (DDR_PAIR_LANE_N == ~DDR_PAIR_LANE_P)
		else $error("lane pair not inverse");
	lane_idle_a: assert property ($changed(DDR_PAIR_LANE_P) |->
		MODE_OUT != 2'h0 || DDR_PAIR_LANE_P == '0) else $error("lane moved");
	rd_quiet_a: assert property (!$past(RD) || $past(ADDR) > 7'h05 ||
		$past(ADDR) < 7'h02 |-> RDATA == 8'h00) else $error("stray read data");
	par_mode_a: assert property ((PROGRAM_MODE_PIN && $stable(SCK_PIN))[*8]
		|-> MODE_OUT == {1'b0, SCK_PIN}) else $error("pin mode not followed");
	lock_off_a: assert property (!$past(DUTY_STABILIZER) |-> !DCS_LOCKED)
		else $error("locked with stabilizer off");
	lock_time_a: assert property ($rose(DCS_LOCKED) |-> on_ff >= LOCK_MIN)
		else $error("locked too early");
	cover property ($rose(DCS_LOCKED));
	cover property (MODE_OUT == 2'h2);
	cover property (RANGE_FLAG_P);
endmodule : aof_checker
bind aof_formatter aof_checker #(.WIDTH(WIDTH)) checker_i (
	.SYS_CLK, .RST_N, .RD, .ADDR, .RDATA, .PROGRAM_MODE_PIN, .SCK_PIN,
	.DDR_PAIR_LANE_P, .DDR_PAIR_LANE_N, .RANGE_FLAG_P, .RANGE_FLAG_N,
	.FWD_CLK_P, .FWD_CLK_N, .MODE_OUT, .DUTY_STABILIZER, .DCS_LOCKED
);

// ---- bench/aof_rx.sv ----
// Purpose: receiving logic model for the formatter outputs
// Assumes: forwarded clock edges sit inside the data eyes
// Notes: DDR even half taken on fall, odd half on rise
`timescale 1ns/1ps
// ****************
// receiver
// ****************
module aof_rx #(
	parameter int W = 14
) (
	input wire logic clk_p,
	input wire logic [W-1:0] bits,
	input wire logic [W/2-1:0] lane,
	input wire logic flag,
	input wire logic [1:0] mode,
	input wire logic [2:0] fmt,
	output logic [W-1:0] word,
	output logic [W-1:0] dec,
	output logic flag_q
);
	logic [W-1:0] full_ff, t;
	logic [W/2-1:0] odd_ff, even_ff;
	always @(posedge clk_p) begin
		full_ff <= bits;
		odd_ff <= lane;
		flag_q <= flag;
	end
	always @(negedge clk_p) begin
		even_ff <= lane;
	end
	always_comb begin
		word = full_ff;
		for (int i = 0; i < W/2; i++) begin
			if (mode != 2'h0) begin
				word[2*i] = even_ff[i];
				word[2*i+1] = odd_ff[i];
			end
		end
		t = fmt[2] ? word ^ {(W/2){2'b10}} : word;
		dec = fmt[1] ? t ^ {{(W-1){t[0]}}, 1'b0} : t;
	end
endmodule : aof_rx

// ---- bench/testbench.sv ----
// Purpose: self-checking bench of the output formatter
// Assumes: 25 MHz SYS_CLK, encode period of 8 cycles
// Notes: sample words seen through the receiver model
`timescale 1ns/1ps
// ****************
// bench
// ****************
module testbench
	import aof_pkg::*;
;
	logic SYS_CLK = 0, RST_N = 0, ENC_CLK = 0, OVER_RANGE = 0, UNDER_RANGE = 0;
	logic PROGRAM_MODE_PIN = 0, CS_PIN = 0, SCK_PIN = 0, WR = 0, RD = 0;
	logic [6:0] ADDR = '0, DDR_PAIR_LANE_P, DDR_PAIR_LANE_N;
	logic [7:0] WDATA = '0, RDATA;
	logic [13:0] SAMPLE_IN = 14'h1a5b, SAMPLE_BITS, rx_word, rx_dec;
	logic RANGE_FLAG_P, RANGE_FLAG_N, FWD_CLK_P, FWD_CLK_N, rx_flag;
	logic INTERNAL_TERM_ENABLE, DUTY_STABILIZER, DCS_LOCKED;
	logic [1:0] MODE_OUT;
	logic [6:0] LVDS_DRIVE_LEVEL;
	logic [2:0] fmt = '0, enc_ph = '0, enc_hi = 3'h4;
	int n_mismatch = 0, comparisons = 0, hi;
	int drv_tbl [16] = '{35, 40, 45, 35, 30, 25, 21, 17,
		56, 64, 72, 56, 48, 40, 33, 28};
	initial begin
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	always @(posedge SYS_CLK) begin
		enc_ph <= enc_ph + 3'h1;
		ENC_CLK <= enc_ph < enc_hi;
	end
	aof_formatter DUT (.SYS_CLK, .RST_N, .ENC_CLK, .SAMPLE_IN, .OVER_RANGE,
		.UNDER_RANGE, .PROGRAM_MODE_PIN, .CS_PIN, .SCK_PIN, .ADDR, .WDATA,
		.WR, .RD, .RDATA, .SAMPLE_BITS, .DDR_PAIR_LANE_P, .DDR_PAIR_LANE_N,
		.RANGE_FLAG_P, .RANGE_FLAG_N, .FWD_CLK_P, .FWD_CLK_N, .MODE_OUT,
		.LVDS_DRIVE_LEVEL, .INTERNAL_TERM_ENABLE, .DUTY_STABILIZER, .DCS_LOCKED);
	aof_rx RX (.clk_p(FWD_CLK_P), .bits(SAMPLE_BITS), .lane(DDR_PAIR_LANE_P),
		.flag(RANGE_FLAG_P), .mode(MODE_OUT), .fmt(fmt), .word(rx_word),
		.dec(rx_dec), .flag_q(rx_flag));
	task test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
		comparisons++;
		if (seen !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk
	task wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
	endtask : wr
	task rchk(input logic [6:0] a, input logic [7:0] e);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		@(posedge SYS_CLK);
		chk("register", {8'h00, RDATA}, {8'h00, e});
	endtask : rchk
	// pipeline settles well within eight encode periods
	task dchk(input logic [13:0] e, input logic fl);
		repeat (64) @(posedge SYS_CLK);
		chk("word", {2'h0, rx_word}, {2'h0, e});
		chk("flag", {15'h0, rx_flag}, {15'h0, fl});
	endtask : dchk
	function automatic logic [13:0] xw(input logic [13:0] s, input logic [2:0] f);
		logic [13:0] w;
		w = s ^ {f[0] & ~f[2], 13'h0000};
		if (f[1]) w = w ^ {{13{w[0]}}, 1'b0};
		if (f[2]) w = w ^ 14'h2aaa;
		return w;
	endfunction : xw
	initial begin
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		rchk(AOF_TIMING_OFS, 8'h00);
		rchk(AOF_OUTMODE_OFS, 8'h00);
		rchk(AOF_FORMAT_OFS, 8'h00);
		rchk(AOF_STATUS_OFS, 8'h00);
		rchk(7'h7f, 8'h00);
		$display("reset values done");
		for (int f = 0; f < 8; f++) begin
			fmt <= 3'(f);
			wr(AOF_FORMAT_OFS, 8'(f));
			rchk(AOF_FORMAT_OFS, 8'(f));
			dchk(xw(SAMPLE_IN, 3'(f)), 1'b0);
			chk("dec", {2'h0, rx_dec},
				{2'h0, xw(SAMPLE_IN, 3'((f & 5) == 1))});
			chk("mode", 16'(MODE_OUT), 16'h0000);
		end
		$display("formats done");
		for (int i = 0; i < 4; i++) begin
			fmt <= 3'(i & 1);
			wr(AOF_FORMAT_OFS, 8'(i & 1));
			OVER_RANGE <= (i > 1);
			UNDER_RANGE <= (i < 2);
			dchk(xw((i > 1) ? 14'h3fff : 14'h0000, 3'(i & 1)), 1'b1);
		end
		OVER_RANGE <= 1'b0;
		UNDER_RANGE <= 1'b0;
		fmt <= 3'h0;
		wr(AOF_FORMAT_OFS, 8'h00);
		dchk(SAMPLE_IN, 1'b0);
		$display("saturation done");
		wr(AOF_TIMING_OFS, 8'h05);
		wr(AOF_OUTMODE_OFS, 8'h01);
		repeat (320) @(posedge SYS_CLK);
		rchk(AOF_STATUS_OFS, 8'h40);
		repeat (600) @(posedge SYS_CLK);
		rchk(AOF_STATUS_OFS, 8'hc0);
		chk("mode", 16'(MODE_OUT), 16'h0001);
		dchk(SAMPLE_IN, 1'b0);
		wr(AOF_TIMING_OFS, 8'h0d);
		// inverted clock swaps the capture edges of each pair
		dchk(((SAMPLE_IN & 14'h1555) << 1) |
			((SAMPLE_IN & 14'h2aaa) >> 1), 1'b0);
		wr(AOF_TIMING_OFS, 8'h05);
		enc_hi <= 3'h3;
		repeat (64) @(posedge SYS_CLK);
		hi = 0;
		repeat (32) begin
			@(posedge SYS_CLK);
			hi += int'(FWD_CLK_P === 1'b1);
		end
		chk("duty", 16'(hi), 16'd16);
		enc_hi <= 3'h4;
		for (int c = 0; c < 16; c++) begin
			wr(AOF_OUTMODE_OFS, {1'b0, 3'(c), 1'(c >> 3), 3'h1});
			repeat (4) @(posedge SYS_CLK);
			chk("drive", 16'(LVDS_DRIVE_LEVEL), 16'(drv_tbl[c]));
			chk("term", 16'(INTERNAL_TERM_ENABLE), 16'(c >> 3));
		end
		$display("lvds done");
		wr(AOF_OUTMODE_OFS, 8'h02);
		dchk(SAMPLE_IN, 1'b0);
		chk("mode", 16'(MODE_OUT), 16'h0002);
		PROGRAM_MODE_PIN <= 1'b1;
		CS_PIN <= 1'b1;
		SCK_PIN <= 1'b1;
		repeat (16) @(posedge SYS_CLK);
		chk("mode", 16'(MODE_OUT), 16'h0001);
		chk("drive", 16'(LVDS_DRIVE_LEVEL), 16'd35);
		chk("dcs", 16'(DUTY_STABILIZER), 16'h0001);
		CS_PIN <= 1'b0;
		SCK_PIN <= 1'b0;
		repeat (16) @(posedge SYS_CLK);
		rchk(AOF_STATUS_OFS, 8'h20);
		dchk(SAMPLE_IN, 1'b0);
		chk("mode", 16'(MODE_OUT), 16'h0000);
		$display("parallel done");
		test_done();
	end
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		n_mismatch++;
		test_done();
	end
endmodule : testbench
